// File: hw/adc_cal_device.sv
// Converter control end: calibration, coefficient copies, ports, sync and overrange
// What this block does
// - Host coefficient copies loaded at conversion start
// - Calibration updates internal coefficients only
// - Readback select picks internal or host copy
// - Bypass bits 0 and 2 gate coefficients 0 and 2; bits 1 and 3 unused
// - Self calibration valid only in scan mode 00
// - Self calibration: offset then full scale
// - Self calibration single cycle at 50 sps
// - Trim type 00, mode 10, within 200 ms
// - Self calibration excludes the gain amplifier
// - System calibration in mode one, selected channel
// - System offset: trim 01, mode 10, 100 ms
// - System gain: trim 10, mode 10, 100 ms
// - Three ports, enable/direction, value for ports 0 and 1 only (port 2 drives 0), inputs at reset
// - Host sets up ports and bits for sync
// - Count mismatch over one restarts the conversion
// - No valid result during filter refill
// - Pulses ignored before first ready fall
// - Filter overflow saturates result, sets digital flag
// - Analog flag set after result update
// - Within reference clears both flags
// - Control write during conversion aborts to standby
// - Mode 11 converts, mode 01 power request
`timescale 1ns/100ps
`default_nettype none
module adc_cal_device #(
    parameter int unsigned SELF_CYCLES = adc_cal_pkg::SELF_CAL_CYCLES,
    parameter int unsigned SYS_CYCLES  = adc_cal_pkg::SYS_CAL_CYCLES,
    parameter int unsigned CONV_CYCLES = adc_cal_pkg::CONV_PERIOD
) (
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    adc_ctrl_if.dev          link,
    input  wire logic [23:0] SAMPLE_VALUE,
    input  wire logic        SAMPLE_OVF_POS,
    input  wire logic        SAMPLE_OVF_NEG,
    input  wire logic        SAMPLE_ANALOG_OVR,
    input  wire logic [2:0]  PORT_IN,
    input  wire logic        ALIGN_PULSE,
    output logic [2:0]       PORT_OUT,
    output logic [2:0]       PORT_OE,
    output logic [1:0]       CAL_INPUT_SEL,
    output logic             PGA_IN_PATH,
    output logic [7:0]       CAL_CHANNEL,
    output logic [1:0]       POWER_REQUEST
);
    typedef logic [23:0] coef_t;

    adc_cal_pkg::dev_state_t state_q;
    adc_cal_pkg::dev_state_t state_d;
    coef_t       host_coef_q [4];
    coef_t       int_coef_q  [4];
    logic [31:0] timer_q;
    logic [23:0] result_q;
    logic        rdy_n_q;
    logic        dor_q;
    logic        aor_q;
    logic        aor_pend_q;
    logic [3:0]  latency_q;
    logic        pulse_prev_q;
    logic [23:0] coef_rd_q;
    logic [2:0]  port_out_q;
    logic [2:0]  port_oe_q;
    logic [2:0]  port_in_q;
    logic [1:0]  cal_sel_q;
    logic        pga_q;
    logic [7:0]  chan_q;
    logic [1:0]  pwr_q;
    logic        sync_restart;

    wire [1:0] trim_type  = link.cfg_ctrl_one[7:6];
    wire [1:0] scan_mode  = link.cfg_scan[1:0];
    wire       readback   = link.cfg_ctrl_three[4];
    wire [3:0] bypass     = link.cfg_ctrl_three[3:0];
    wire       sync_mode  = link.cfg_ctrl_three[5];
    wire       ext_tb     = link.cfg_ctrl_two[7];
    wire       cmd_conv   = link.cmd_valid && link.cmd_mode == adc_cal_pkg::CMD_CONVERT;
    wire       cmd_cal    = link.cmd_valid && link.cmd_mode == adc_cal_pkg::CMD_CAL;
    wire       cmd_pwr    = link.cmd_valid && link.cmd_mode == adc_cal_pkg::CMD_POWER;
    wire       mode_one   = scan_mode == adc_cal_pkg::SCAN_MODE_ONE;
    wire       cal_ok     = cmd_cal && mode_one;
    wire       idle       = state_q == adc_cal_pkg::ST_STANDBY;
    wire       timer_done = timer_q == 32'h0000_0000;
    wire       conv_done  = state_q == adc_cal_pkg::ST_CONVERT && timer_done;
    wire       sync_en    = sync_mode && ext_tb && !link.cfg_ports[7] && !link.cfg_ports[6];
    wire       pulse_rise = ALIGN_PULSE && !pulse_prev_q;
    wire       filling    = latency_q != 4'h0;
    // Every reported result counts as a data-ready edge for sync
    wire       ready_fall = conv_done && !filling;
    wire [23:0] corrected = SAMPLE_VALUE
                          - (bypass[0] ? 24'h00_0000 : int_coef_q[0])
                          - (bypass[2] ? 24'h00_0000 : int_coef_q[2]);

    // Next state of the sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            adc_cal_pkg::ST_STANDBY: begin
                if (cmd_conv) begin
                    state_d = adc_cal_pkg::ST_CONVERT;
                end else if (cal_ok && trim_type == adc_cal_pkg::TRIM_SELF) begin
                    state_d = adc_cal_pkg::ST_CAL_OFS;
                end else if (cal_ok && (trim_type == adc_cal_pkg::TRIM_SYS_OFS
                                     || trim_type == adc_cal_pkg::TRIM_SYS_GAIN)) begin
                    state_d = adc_cal_pkg::ST_SYS_CAL;
                end
            end
            adc_cal_pkg::ST_CONVERT: begin
                if (link.cfg_wr) state_d = adc_cal_pkg::ST_STANDBY;
            end
            adc_cal_pkg::ST_CAL_OFS: begin
                if (timer_done) state_d = adc_cal_pkg::ST_CAL_GAIN;
            end
            adc_cal_pkg::ST_CAL_GAIN,
            adc_cal_pkg::ST_SYS_CAL: begin
                if (timer_done) state_d = adc_cal_pkg::ST_STANDBY;
            end
            default: state_d = adc_cal_pkg::ST_STANDBY;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= adc_cal_pkg::ST_STANDBY;
            timer_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            if (state_d != state_q || (conv_done && state_d == state_q) || sync_restart) begin
                unique case (state_d)
                    adc_cal_pkg::ST_CONVERT:  timer_q <= CONV_CYCLES - 1;
                    adc_cal_pkg::ST_CAL_OFS,
                    adc_cal_pkg::ST_CAL_GAIN: timer_q <= SELF_CYCLES / 2 - 1;
                    adc_cal_pkg::ST_SYS_CAL:  timer_q <= SYS_CYCLES - 1;
                    default:                  timer_q <= 32'h0000_0000;
                endcase
            end else if (!timer_done) begin
                timer_q <= timer_q - 32'h0000_0001;
            end
        end
    end

    // Coefficient storage, one generate entry per coefficient
    for (genvar i = 0; i < 4; i++) begin : g_coef
        always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                host_coef_q[i] <= adc_cal_pkg::COEF_RST;
                int_coef_q[i]  <= adc_cal_pkg::COEF_RST;
            end else begin
                if (link.coef_wr && link.coef_sel == 2'(i)) begin
                    host_coef_q[i] <= link.coef_wdata;
                end
                if (idle && state_d == adc_cal_pkg::ST_CONVERT) begin
                    int_coef_q[i] <= host_coef_q[i];
                end else if (timer_done && ((i == 0 && state_q == adc_cal_pkg::ST_CAL_OFS)
                        || (i == 1 && state_q == adc_cal_pkg::ST_CAL_GAIN)
                        || (i == 2 && state_q == adc_cal_pkg::ST_SYS_CAL && cal_sel_q == 2'h1)
                        || (i == 3 && state_q == adc_cal_pkg::ST_SYS_CAL && cal_sel_q == 2'h2))) begin
                    int_coef_q[i] <= SAMPLE_VALUE;
                end
            end
        end
    end

    sync_checker u_sync (
        .CLK        (CLK),
        .ARST_N     (ARST_N),
        .enable     (sync_en && state_q == adc_cal_pkg::ST_CONVERT),
        .ready_fall (ready_fall),
        .pulse_rise (pulse_rise),
        .restart    (sync_restart)
    );

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            result_q     <= 24'h00_0000;
            rdy_n_q      <= 1'b1;
            dor_q        <= 1'b0;
            aor_q        <= 1'b0;
            aor_pend_q   <= 1'b0;
            latency_q    <= 4'h0;
            pulse_prev_q <= 1'b0;
        end else begin
            pulse_prev_q <= ALIGN_PULSE;
            aor_q        <= aor_pend_q;
            if (sync_restart) begin
                latency_q <= 4'(adc_cal_pkg::FILTER_LATENCY);
                rdy_n_q   <= 1'b1;
            end else if (conv_done && filling) begin
                latency_q <= latency_q - 4'h1;
            end else if (conv_done) begin
                rdy_n_q    <= 1'b0;
                dor_q      <= SAMPLE_OVF_POS || SAMPLE_OVF_NEG;
                aor_pend_q <= SAMPLE_ANALOG_OVR || SAMPLE_OVF_POS || SAMPLE_OVF_NEG;
                if (SAMPLE_OVF_POS) begin
                    result_q <= adc_cal_pkg::POS_FULL;
                end else if (SAMPLE_OVF_NEG) begin
                    result_q <= adc_cal_pkg::NEG_FULL;
                end else begin
                    result_q <= corrected;
                end
            end else if (link.cmd_valid) begin
                rdy_n_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            coef_rd_q  <= 24'h00_0000;
            port_out_q <= 3'h0;
            port_oe_q  <= 3'h0;
            port_in_q  <= 3'h0;
            cal_sel_q  <= 2'h0;
            pga_q      <= 1'b0;
            chan_q     <= 8'h00;
            pwr_q      <= 2'h0;
        end else begin
            coef_rd_q  <= readback ? host_coef_q[link.coef_sel] : int_coef_q[link.coef_sel];
            port_oe_q  <= link.cfg_ports[7:5] & link.cfg_ports[4:2];
            port_out_q <= {1'b0, link.cfg_ports[1:0]} & link.cfg_ports[4:2];
            port_in_q  <= PORT_IN;
            chan_q     <= link.cfg_scan[7:2] == 6'h00 ? 8'h00 : {2'h0, link.cfg_scan[7:2]};
            if (cmd_pwr) pwr_q <= link.cfg_ctrl_one[5:4];
            unique case (state_d)
                adc_cal_pkg::ST_CAL_OFS:  cal_sel_q <= 2'h1;
                adc_cal_pkg::ST_CAL_GAIN: cal_sel_q <= 2'h2;
                adc_cal_pkg::ST_SYS_CAL:  cal_sel_q <= trim_type == adc_cal_pkg::TRIM_SYS_OFS ? 2'h1 : 2'h2;
                default:                  cal_sel_q <= 2'h0;
            endcase
            pga_q <= state_d == adc_cal_pkg::ST_SYS_CAL || state_d == adc_cal_pkg::ST_CONVERT;
        end
    end

    assign link.coef_rdata             = coef_rd_q;
    assign link.result                 = result_q;
    assign link.data_ready_n           = rdy_n_q;
    assign link.digital_overrange_flag = dor_q;
    assign link.analog_overrange_flag  = aor_q;
    assign link.busy                   = !idle;
    assign link.port_in                = port_in_q;
    assign PORT_OUT      = port_out_q;
    assign PORT_OE       = port_oe_q;
    assign CAL_INPUT_SEL = cal_sel_q;
    assign PGA_IN_PATH   = pga_q;
    assign CAL_CHANNEL   = chan_q;
    assign POWER_REQUEST = pwr_q;
endmodule : adc_cal_device
`default_nettype wire

// File: hw/adc_cal_host.sv
// Host controller end: APB registers drive the converter control link
`timescale 1ns/100ps
`default_nettype none
module adc_cal_host (
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    adc_ctrl_if.host         link,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);
    logic [31:0] ctrl_q;
    logic [7:0]  ports_q;
    logic        cfg_wr_q;
    logic        cmd_valid_q;
    logic [1:0]  cmd_mode_q;
    logic        coef_wr_q;
    logic [1:0]  coef_sel_q;
    logic [23:0] coef_wdata_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    wire access = PSEL && PENABLE && !pready_q;
    wire wr     = PSEL && PENABLE && pready_q && PWRITE;
    wire rd     = access && !PWRITE;
    wire hit    = PADDR == adc_cal_pkg::R_CTRL || PADDR == adc_cal_pkg::R_CMD
               || PADDR == adc_cal_pkg::R_STATUS || PADDR == adc_cal_pkg::R_COEF
               || PADDR == adc_cal_pkg::R_RESULT || PADDR == adc_cal_pkg::R_PORTS
               || PADDR == adc_cal_pkg::R_WCOEF;
    wire [31:0] rd_mux =
        PADDR == adc_cal_pkg::R_CTRL   ? ctrl_q :
        PADDR == adc_cal_pkg::R_STATUS ? {28'h000_0000, link.busy, link.data_ready_n,
                                          link.digital_overrange_flag, link.analog_overrange_flag} :
        PADDR == adc_cal_pkg::R_COEF   ? {6'h00, coef_sel_q, link.coef_rdata} :
        PADDR == adc_cal_pkg::R_RESULT ? {8'h00, link.result} :
        PADDR == adc_cal_pkg::R_PORTS  ? {21'h00_0000, link.port_in, ports_q} : 32'h0000_0000;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_q       <= 32'h0000_0000;
            ports_q      <= 8'h00;
            cfg_wr_q     <= 1'b0;
            cmd_valid_q  <= 1'b0;
            cmd_mode_q   <= 2'h0;
            coef_wr_q    <= 1'b0;
            coef_sel_q   <= 2'h0;
            coef_wdata_q <= 24'h00_0000;
            prdata_q     <= 32'h0000_0000;
            pready_q     <= 1'b0;
            pslverr_q    <= 1'b0;
        end else begin
            pready_q    <= access;
            pslverr_q   <= access && !hit;
            prdata_q    <= rd ? rd_mux : 32'h0000_0000;
            cfg_wr_q    <= wr && PADDR == adc_cal_pkg::R_CTRL;
            cmd_valid_q <= wr && PADDR == adc_cal_pkg::R_CMD;
            coef_wr_q   <= wr && PADDR == adc_cal_pkg::R_WCOEF;
            if (wr && PADDR == adc_cal_pkg::R_CTRL) ctrl_q <= PWDATA;
            if (wr && PADDR == adc_cal_pkg::R_PORTS) ports_q <= PWDATA[7:0];
            if (wr && PADDR == adc_cal_pkg::R_CMD) cmd_mode_q <= PWDATA[1:0];
            if (wr && (PADDR == adc_cal_pkg::R_COEF || PADDR == adc_cal_pkg::R_WCOEF)) begin
                coef_sel_q <= PWDATA[25:24];
            end
            if (wr && PADDR == adc_cal_pkg::R_WCOEF) coef_wdata_q <= PWDATA[23:0];
        end
    end

    assign link.cfg_ctrl_one   = ctrl_q[7:0];
    assign link.cfg_ctrl_two   = ctrl_q[15:8];
    assign link.cfg_ctrl_three = ctrl_q[23:16];
    assign link.cfg_scan       = ctrl_q[31:24];
    assign link.cfg_ports      = ports_q;
    assign link.cfg_wr         = cfg_wr_q;
    assign link.cmd_valid      = cmd_valid_q;
    assign link.cmd_mode       = cmd_mode_q;
    assign link.coef_wr        = coef_wr_q;
    assign link.coef_sel       = coef_sel_q;
    assign link.coef_wdata     = coef_wdata_q;
    assign PRDATA  = prdata_q;
    assign PREADY  = pready_q;
    assign PSLVERR = pslverr_q;
endmodule : adc_cal_host
`default_nettype wire

// File: hw/adc_cal_pkg.sv
// Constants, types and timing shared by both ends of the converter control link
package adc_cal_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned SELF_CAL_MS     = 200;
    localparam int unsigned SYS_CAL_MS      = 100;
    localparam int unsigned SELF_CAL_CYCLES = SELF_CAL_MS * (CLK_HZ / 1000);
    localparam int unsigned SYS_CAL_CYCLES  = SYS_CAL_MS * (CLK_HZ / 1000);
    localparam int unsigned FILTER_LATENCY  = 5;
    localparam int unsigned CONV_PERIOD     = 500_000;
    localparam int unsigned CNT_W           = 20;
    localparam int unsigned DATA_W          = 24;
    localparam int unsigned PORT_N          = 3;

    localparam logic [1:0] SCAN_MODE_ONE  = 2'h0;
    localparam logic [1:0] CMD_POWER      = 2'h1;
    localparam logic [1:0] CMD_CAL        = 2'h2;
    localparam logic [1:0] CMD_CONVERT    = 2'h3;
    localparam logic [1:0] TRIM_SELF      = 2'h0;
    localparam logic [1:0] TRIM_SYS_OFS   = 2'h1;
    localparam logic [1:0] TRIM_SYS_GAIN  = 2'h2;

    localparam logic [23:0] POS_FULL  = 24'h7F_FFFF;
    localparam logic [23:0] NEG_FULL  = 24'h80_0000;
    localparam logic [23:0] COEF_RST  = 24'h00_0000;

    // Register indices of the host controller's APB slave
    localparam logic [7:0] R_CTRL    = 8'h00;
    localparam logic [7:0] R_CMD     = 8'h04;
    localparam logic [7:0] R_STATUS  = 8'h08;
    localparam logic [7:0] R_COEF    = 8'h0C;
    localparam logic [7:0] R_RESULT  = 8'h10;
    localparam logic [7:0] R_PORTS   = 8'h14;
    localparam logic [7:0] R_WCOEF   = 8'h18;

    typedef enum logic [2:0] {
        ST_STANDBY  = 3'b000,
        ST_CONVERT  = 3'b001,
        ST_CAL_OFS  = 3'b010,
        ST_CAL_GAIN = 3'b011,
        ST_SYS_CAL  = 3'b100
    } dev_state_t;
endpackage : adc_cal_pkg

// File: hw/adc_ctrl_if.sv
// Interface joining the converter control logic and its host controller
`timescale 1ns/100ps
`default_nettype none
interface adc_ctrl_if;
    logic [7:0]  cfg_ctrl_one;
    logic [7:0]  cfg_ctrl_two;
    logic [7:0]  cfg_ctrl_three;
    logic [7:0]  cfg_ports;
    logic [7:0]  cfg_scan;
    logic        cfg_wr;
    logic        cmd_valid;
    logic [1:0]  cmd_mode;
    logic        coef_wr;
    logic [1:0]  coef_sel;
    logic [23:0] coef_wdata;
    logic [23:0] coef_rdata;
    logic [23:0] result;
    logic        data_ready_n;
    logic        digital_overrange_flag;
    logic        analog_overrange_flag;
    logic        busy;
    logic [2:0]  port_in;
    modport dev (input cfg_ctrl_one, cfg_ctrl_two, cfg_ctrl_three, cfg_ports, cfg_scan, cfg_wr,
                 cmd_valid, cmd_mode, coef_wr, coef_sel, coef_wdata,
                 output coef_rdata, result, data_ready_n, digital_overrange_flag,
                 analog_overrange_flag, busy, port_in);
    modport host (output cfg_ctrl_one, cfg_ctrl_two, cfg_ctrl_three, cfg_ports, cfg_scan, cfg_wr,
                  cmd_valid, cmd_mode, coef_wr, coef_sel, coef_wdata,
                  input coef_rdata, result, data_ready_n, digital_overrange_flag,
                  analog_overrange_flag, busy, port_in);
endinterface : adc_ctrl_if
`default_nettype wire

// File: hw/sync_checker.sv
// Alignment pulse timing checker for external-timebase sync mode
`timescale 1ns/100ps
`default_nettype none
module sync_checker #(
    parameter int unsigned CW = adc_cal_pkg::CNT_W
) (
    input  wire logic CLK,
    input  wire logic ARST_N,
    input  wire logic enable,
    input  wire logic ready_fall,
    input  wire logic pulse_rise,
    output logic      restart
);
    logic          armed_q;
    logic          counting_q;
    logic          have_ref_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] ref_q;
    logic          restart_q;

    wire           sample   = enable && armed_q && counting_q && pulse_rise;
    wire [CW-1:0]  diff     = (count_q > ref_q) ? count_q - ref_q : ref_q - count_q;
    wire           mismatch = sample && have_ref_q && (diff > CW'(1));
    wire           sat      = &count_q;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            armed_q    <= 1'b0;
            counting_q <= 1'b0;
            have_ref_q <= 1'b0;
            count_q    <= '0;
            ref_q      <= '0;
            restart_q  <= 1'b0;
        end else if (!enable) begin
            armed_q    <= 1'b0;
            counting_q <= 1'b0;
            have_ref_q <= 1'b0;
            restart_q  <= 1'b0;
        end else begin
            restart_q <= mismatch;
            if (ready_fall) begin
                armed_q    <= 1'b1;
                counting_q <= 1'b1;
                count_q    <= '0;
            end else if (sample) begin
                counting_q <= 1'b0;
            end else if (counting_q && !sat) begin
                count_q <= count_q + CW'(1);
            end
            if (sample && !have_ref_q) begin
                ref_q      <= count_q;
                have_ref_q <= 1'b1;
            end
        end
    end

    assign restart = restart_q;
endmodule : sync_checker
`default_nettype wire

// File: verification/adc_cal_properties.sv
// Concurrent checks on the link between the host controller and the converter control end
`timescale 1ns/100ps
`default_nettype none
module adc_cal_properties #(
    parameter int unsigned SELF_CYCLES = 40,
    parameter int unsigned SYS_CYCLES  = 20
) (
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic        cmd_valid,
    input wire logic [1:0]  cmd_mode,
    input wire logic [7:0]  cfg_ctrl_one,
    input wire logic [7:0]  cfg_scan,
    input wire logic [23:0] result,
    input wire logic        data_ready_n,
    input wire logic        digital_overrange_flag,
    input wire logic        analog_overrange_flag,
    input wire logic        busy
);
    localparam int SELF_MAX = SELF_CYCLES + 5;
    localparam int SYS_MAX  = SYS_CYCLES + 5;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    wire cal_go = cmd_valid && cmd_mode == adc_cal_pkg::CMD_CAL && !busy;
    wire scan0  = cfg_scan[1:0] == adc_cal_pkg::SCAN_MODE_ONE;
    wire trim_s = cfg_ctrl_one[7:6] == adc_cal_pkg::TRIM_SELF;
    wire trim_y = cfg_ctrl_one[7:6] == adc_cal_pkg::TRIM_SYS_OFS || cfg_ctrl_one[7:6] == adc_cal_pkg::TRIM_SYS_GAIN;

    a_overflow_saturates: assert property ($fell(data_ready_n) && digital_overrange_flag |->
        result == adc_cal_pkg::POS_FULL || result == adc_cal_pkg::NEG_FULL) else $error("overflow result not saturated");
    a_digital_sets_analog: assert property ($fell(data_ready_n) && digital_overrange_flag |=> analog_overrange_flag)
        else $error("analog flag missing after overflow");
    a_analog_after_result: assert property ($rose(analog_overrange_flag) |-> !data_ready_n)
        else $error("analog flag rose without a new result");
    a_cal_ignored: assert property (cal_go && !scan0 |=> !busy) else $error("calibration accepted outside scan mode");
    a_self_cal_len: assert property (cal_go && scan0 && trim_s |=> busy [*8] ##[1:SELF_MAX] !busy)
        else $error("self calibration length wrong");
    a_sys_cal_len: assert property (cal_go && scan0 && trim_y |=> busy [*8] ##[1:SYS_MAX] !busy)
        else $error("system calibration length wrong");
    a_convert_starts: assert property (cmd_valid && cmd_mode == adc_cal_pkg::CMD_CONVERT |-> ##[1:2] busy)
        else $error("convert command did not start");
    a_power_no_run: assert property (cmd_valid && cmd_mode == adc_cal_pkg::CMD_POWER && !busy |=> !busy)
        else $error("power command started a run");
endmodule : adc_cal_properties
`default_nettype wire

// File: verification/adc_calibration_sync_overrange_bench.sv
// Self-checking bench joining both ends of the converter control link
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module adc_calibration_sync_overrange_bench;
    import adc_cal_pkg::*;
    typedef struct {logic [23:0] s; logic p; logic n; logic a; logic [23:0] r; logic [1:0] f;} row_t;
    row_t        rows [4] = '{'{24'h12_3456, 1'h0, 1'h0, 1'h0, 24'h12_3456, 2'h0}, '{24'h00_1000, 1'h0, 1'h0, 1'h1, 24'h00_1000, 2'h1},
                              '{24'h00_0001, 1'h1, 1'h0, 1'h1, POS_FULL, 2'h3}, '{24'h00_0002, 1'h0, 1'h1, 1'h1, NEG_FULL, 2'h3}};
    logic        CLK = 0, ARST_N = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic        opos = 0, oneg = 0, oana = 0, sync = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [23:0] sval = 0;
    logic [2:0]  pout, poe;
    logic [1:0]  pwr, csel;
    int          miscompares = 0, n_compared = 0, cyc = 0, per = 0;
    adc_ctrl_if link();
    adc_cal_device #(.SELF_CYCLES(40), .SYS_CYCLES(20), .CONV_CYCLES(50)) i_adc_cal_device (.CLK(CLK), .ARST_N(ARST_N),
        .link(link), .SAMPLE_VALUE(sval), .SAMPLE_OVF_POS(opos), .SAMPLE_OVF_NEG(oneg), .SAMPLE_ANALOG_OVR(oana),
        .PORT_IN(3'h5), .ALIGN_PULSE(sync), .PORT_OUT(pout), .PORT_OE(poe), .CAL_INPUT_SEL(csel), .PGA_IN_PATH(),
        .CAL_CHANNEL(), .POWER_REQUEST(pwr));
    adc_cal_host i_adc_cal_host (.CLK(CLK), .ARST_N(ARST_N), .link(link), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    adc_cal_properties #(.SELF_CYCLES(40), .SYS_CYCLES(20)) i_adc_cal_properties (.CLK(CLK), .ARST_N(ARST_N),
        .cmd_valid(link.cmd_valid), .cmd_mode(link.cmd_mode), .cfg_ctrl_one(link.cfg_ctrl_one), .cfg_scan(link.cfg_scan),
        .result(link.result), .data_ready_n(link.data_ready_n), .digital_overrange_flag(link.digital_overrange_flag),
        .analog_overrange_flag(link.analog_overrange_flag), .busy(link.busy));

    initial begin
        forever #20 CLK = ~CLK;
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge CLK) penable <= 1'h1;
        do @(posedge CLK); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0; penable <= 1'h0;
        @(posedge CLK);
    endtask : apb

    task automatic wait_st(input int b, input logic v);
        repeat (100) begin
            apb(1'h0, R_STATUS, 32'h0);
            if (rd[b] === v) break;
        end
        `CHK(rd[b], v)
    endtask : wait_st

    task automatic rdc(input logic [1:0] sel, input logic [23:0] exp);
        apb(1'h1, R_COEF, {6'h0, sel, 24'h0});
        apb(1'h0, R_COEF, 32'h0);
        `CHK(rd[23:0], exp)
    endtask : rdc

    function automatic logic [31:0] ctrl(input logic [7:0] scan, input logic [7:0] c3, input logic [1:0] trim);
        return {scan, c3, 8'h00, trim, 6'h00};
    endfunction : ctrl

    task final_report;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    always @(posedge CLK) begin
        cyc <= cyc + 1;
        sync <= per > 0 && cyc % per == 0;
        if (cyc == 20000) begin
            miscompares++;
            final_report;
        end
    end

    initial begin
        repeat (6) @(posedge CLK);
        ARST_N <= 1'h1;
        @(posedge CLK);
        `CHK(poe, 3'h0)
        apb(1'h1, R_CTRL, ctrl(8'h00, 8'h00, TRIM_SELF));
        foreach (rows[i]) begin
            sval <= rows[i].s; opos <= rows[i].p; oneg <= rows[i].n; oana <= rows[i].a;
            apb(1'h1, R_CMD, 32'h3);
            wait_st(2, 1'h0);
            apb(1'h0, R_RESULT, 32'h0);
            `CHK(rd[23:0], rows[i].r)
            apb(1'h0, R_STATUS, 32'h0);
            `CHK(rd[1:0], rows[i].f)
            apb(1'h1, R_CTRL, ctrl(8'h00, 8'h00, TRIM_SELF));
            wait_st(3, 1'h0);
            $display("Convert row %0d done", i);
        end
        sval <= 24'h00_0010;
        apb(1'h1, R_CMD, 32'h2);
        wait_st(3, 1'h0);
        rdc(2'h0, 24'h00_0010);
        rdc(2'h1, 24'h00_0010);
        apb(1'h1, R_CTRL, ctrl(8'h00, 8'h10, TRIM_SYS_OFS));
        rdc(2'h0, 24'h00_0000);
        sval <= 24'h00_0020;
        apb(1'h1, R_CMD, 32'h2);
        @(posedge CLK);
        `CHK(csel, 2'h1)
        wait_st(3, 1'h0);
        rdc(2'h2, 24'h00_0000);
        apb(1'h1, R_CTRL, ctrl(8'h01, 8'h00, TRIM_SELF));
        rdc(2'h2, 24'h00_0020);
        sval <= 24'h00_0055;
        apb(1'h1, R_CMD, 32'h2);
        apb(1'h0, R_STATUS, 32'h0);
        `CHK(rd[3], 1'h0)
        rdc(2'h0, 24'h00_0010);
        $display("Calibration tests done");
        apb(1'h1, R_WCOEF, 32'h0000_0003);
        apb(1'h1, R_CTRL, ctrl(8'h00, 8'h1F, TRIM_SELF));
        rdc(2'h0, 24'h00_0003);
        apb(1'h1, R_CTRL, ctrl(8'h00, 8'h0F, TRIM_SELF));
        sval <= 24'h00_0100;
        oneg <= 1'h0; oana <= 1'h0;
        apb(1'h1, R_CMD, 32'h3);
        wait_st(2, 1'h0);
        apb(1'h0, R_RESULT, 32'h0);
        `CHK(rd[23:0], 24'h00_0100)
        rdc(2'h0, 24'h00_0003);
        apb(1'h1, R_CTRL, ctrl(8'h00, 8'h0F, TRIM_SELF) | 32'h30);
        apb(1'h1, R_CMD, 32'h1);
        wait_st(3, 1'h0);
        `CHK(pwr, 2'h3)
        apb(1'h1, R_CTRL, 32'h0020_8000);
        per <= 50;
        apb(1'h1, R_CMD, 32'h3);
        wait_st(2, 1'h0);
        per <= 37;
        wait_st(2, 1'h1);
        per <= 0;
        repeat (150) @(posedge CLK);
        apb(1'h0, R_STATUS, 32'h0);
        `CHK(rd[2], 1'h1)
        wait_st(2, 1'h0);
        $display("Coefficient and sync tests done");
        apb(1'h1, R_PORTS, 32'h0000_00FE);
        repeat (2) @(posedge CLK);
        `CHK(poe, 3'h7)
        `CHK(pout, 3'h2)
        apb(1'h0, R_PORTS, 32'h0);
        `CHK(rd[10:8], 3'h5)
        apb(1'h0, 8'h40, 32'h0);
        `CHK(err, 1'h1)
        $display("Port and decode tests done");
        final_report;
    end
endmodule : adc_calibration_sync_overrange_bench
`default_nettype wire
